// File: sspi_codec.sv
`timescale 1ns/10ps
module sspi_codec (
	output logic                    bclk,
	input  wire logic               echo_en,
	input  wire logic               bclk_w,
	input  wire logic               txd,
	input  wire logic               pin_a,
	input  wire logic               pin_b,
	input  wire logic               pin_c,
	output logic                    rxd_o,
	output logic                    rxd_oe,
	output logic [sspi_pkg::DW-1:0] w0,
	output logic [sspi_pkg::DW-1:0] w1,
	output logic [sspi_pkg::DW-1:0] w2,
	output logic [7:0]              frames
);
	import sspi_pkg::*;
	logic [DW-1:0] sh_q [3];
	logic [3:0]    cnt_q = 4'h0;
	wire  [2:0]    lanes = {pin_b, pin_a, txd};
	initial
	begin
		frames = 8'h00;
		bclk = 1'b0;
		forever #7.5 bclk = ~bclk; // continuous form
	end
	// echo keeps the receiver busy without a second word source
	assign rxd_oe = echo_en;
	assign rxd_o = txd;
	assign w0 = sh_q[0];
	assign w1 = sh_q[1];
	assign w2 = sh_q[2];
	always @(posedge bclk_w)
	begin
		if (cnt_q != 4'h0)
		begin
			for (int i = 0; i < 3; i++) sh_q[i] <= {sh_q[i][DW-2:0], lanes[i]};
			cnt_q <= cnt_q - 4'h1;
			if (cnt_q == 4'h1) frames <= frames + 8'h01;
		end
		else if (pin_c) // sync seen with msb on the lines
		begin
			for (int i = 0; i < 3; i++) sh_q[i] <= {{(DW-1){1'b0}}, lanes[i]};
			cnt_q <= 4'hf;
		end
	end
endmodule // sspi_codec

// File: sspi_lane.sv
`timescale 1ns/10ps
module sspi_lane
	import sspi_pkg::*;
(
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          ce,
	input  wire logic          load,
	input  wire logic [DW-1:0] word_in,
	input  wire logic          shift,
	input  wire logic          ser_in,
	output logic               ser_out,
	output logic      [DW-1:0] word
);
	logic [DW-1:0] sh_q;

	// msb first; load wins over shift
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			sh_q <= WORD_RST;
		else if (ce && load)
			sh_q <= word_in;
		else if (ce && shift)
			sh_q <= {sh_q[DW-2:0], ser_in};
	end

	assign ser_out = sh_q[DW-1];
	assign word    = sh_q;
endmodule // sspi_lane

// File: sspi_pkg.sv
package sspi_pkg;

	// widths
	localparam int DW        = 16;
	localparam int AW        = 4;
	localparam int WORD_BITS = 16;
	localparam int CNT_W     = 4;
	localparam int DIV_W     = 8;
	localparam int NPIN      = 6;
	localparam int CTRL_W    = 10;
	localparam int TSYNC_W   = 4;
	localparam int RSYNC_W   = 6;
	localparam int TOG_W     = 3;

	// register offsets on the plain register port
	localparam logic [AW-1:0] ADDR_CTRL    = 4'h0;
	localparam logic [AW-1:0] ADDR_FLAG    = 4'h1;
	localparam logic [AW-1:0] ADDR_CLKDIV  = 4'h2;
	localparam logic [AW-1:0] ADDR_TX0     = 4'h3;
	localparam logic [AW-1:0] ADDR_TX1     = 4'h4;
	localparam logic [AW-1:0] ADDR_TX2     = 4'h5;
	localparam logic [AW-1:0] ADDR_STATUS  = 4'h6;
	localparam logic [AW-1:0] ADDR_RXDATA  = 4'h7;
	localparam logic [AW-1:0] ADDR_GDIR    = 4'h8;
	localparam logic [AW-1:0] ADDR_GOUT    = 4'h9;
	localparam logic [AW-1:0] ADDR_GIN     = 4'ha;

	// control field positions
	localparam int CTRL_EN      = 0;
	localparam int CTRL_ASYNC   = 1;
	localparam int CTRL_CLK_OUT = 2;
	localparam int CTRL_GATED   = 3;
	localparam int CTRL_FS_OUT  = 4;
	localparam int CTRL_A_OUT   = 5;
	localparam int CTRL_B_OUT   = 6;
	localparam int CTRL_A_TX    = 7;
	localparam int CTRL_B_TX    = 8;
	localparam int CTRL_RX_EN   = 9;

	// pin positions in pin vectors
	localparam int PIN_TXD  = 0;
	localparam int PIN_RXD  = 1;
	localparam int PIN_BCLK = 2;
	localparam int PIN_A    = 3;
	localparam int PIN_B    = 4;
	localparam int PIN_C    = 5;

	// values after reset
	localparam logic [CTRL_W-1:0] CTRL_RST   = 10'h000;
	localparam logic [1:0]        FLAG_RST   = 2'h0;
	localparam logic [DIV_W-1:0]  CLKDIV_RST = 8'h03;
	localparam logic [NPIN-1:0]   GPIO_RST   = 6'h00;
	localparam logic [DW-1:0]     WORD_RST   = 16'h0000;

	// cycle counts
	localparam logic [CNT_W-1:0] CNT_LAST  = 4'hf;
	localparam logic [CNT_W-1:0] CNT_FIRST = 4'h1;

	typedef enum logic {SEQ_IDLE, SEQ_SHIFT} sspi_seq_type;

endpackage

// File: sspi_sync2.sv
`timescale 1ns/10ps
module sspi_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	// crossing flops keep running under reset and clock enable
	logic [W-1:0] meta_q;
	logic [W-1:0] q_q;

	always_ff @(posedge clk)
	begin
		meta_q <= d;
		q_q    <= meta_q;
	end

	assign q = q_q;
endmodule // sspi_sync2

// File: sspi_top.sv
`timescale 1ns/10ps
// Contract
// - tx data pin shifts out transmit register
// - rx data pin shifts into receive register
// - bit clock pin clocks tx, rx in sync
// - bit clock free running or gated
// - async: pin a is receive clock
// - sync: pin a is tx1 or flag0
// - async: pin b is receive frame sync
// - sync: pin b is tx2 or flag1
// - pin c frame sync, shared in sync
// - pin c drives or takes frame sync
// - unused port: six pins are gpio
module sspi_top (
	input  wire logic                    clk,
	input  wire logic                    rst_n,
	input  wire logic                    ce,
	input  wire logic [sspi_pkg::AW-1:0] addr,
	input  wire logic [sspi_pkg::DW-1:0] wdata,
	input  wire logic                    wr_en,
	input  wire logic                    rd_en,
	output logic      [sspi_pkg::DW-1:0] rdata,
	input  wire logic                    serial_tx_data_pin_i,
	output logic                         serial_tx_data_pin_o,
	output logic                         serial_tx_data_pin_oe,
	input  wire logic                    serial_rx_data_pin_i,
	output logic                         serial_rx_data_pin_o,
	output logic                         serial_rx_data_pin_oe,
	input  wire logic                    serial_bit_clock_pin_i,
	output logic                         serial_bit_clock_pin_o,
	output logic                         serial_bit_clock_pin_oe,
	input  wire logic                    serial_ctrl_pin_a_i,
	output logic                         serial_ctrl_pin_a_o,
	output logic                         serial_ctrl_pin_a_oe,
	input  wire logic                    serial_ctrl_pin_b_i,
	output logic                         serial_ctrl_pin_b_o,
	output logic                         serial_ctrl_pin_b_oe,
	input  wire logic                    serial_ctrl_pin_c_i,
	output logic                         serial_ctrl_pin_c_o,
	output logic                         serial_ctrl_pin_c_oe
);
	import sspi_pkg::*;

	// system clock domain state
	logic [CTRL_W-1:0]  ctrl_q;
	logic [1:0]         flag_q;
	logic [DIV_W-1:0]   div_q;
	logic [DIV_W-1:0]   dcnt_q;
	logic [DW-1:0]      tx0_q;
	logic [DW-1:0]      tx1_q;
	logic [DW-1:0]      tx2_q;
	logic [NPIN-1:0]    gdir_q;
	logic [NPIN-1:0]    gout_q;
	logic               pend_q;
	logic               req_tog_q;
	logic               run_q;
	logic               bclk_q;
	logic [DW-1:0]      rx_data_q;
	logic               rx_full_q;
	logic [TOG_W-1:0]   tog_prev_q;
	logic [DW-1:0]      rdata_q;
	logic [NPIN-1:0]    pin_s;
	logic [TOG_W-1:0]   tog_s;

	// transmit link domain state
	sspi_seq_type       tstate_q;
	logic [CNT_W-1:0]   tcnt_q;
	logic               ack_tog_q;
	logic               end_tog_q;
	logic               fs_q;
	logic [TSYNC_W-1:0] tsync;
	logic               tx0_ser;
	logic               tx1_ser;
	logic               tx2_ser;

	// receive link domain state
	sspi_seq_type       rstate_q;
	logic [CNT_W-1:0]   rcnt_q;
	logic               rx_tog_q;
	logic               rfs_q;
	logic [DW-1:0]      rx_word_q;
	logic [RSYNC_W-1:0] rsync;
	logic [DW-1:0]      rlane_word;

	// configuration decode
	wire port_en  = ctrl_q[CTRL_EN];
	wire async_md = ctrl_q[CTRL_ASYNC];
	wire gated    = ctrl_q[CTRL_GATED];

	// register port decode
	wire wr_ctrl  = wr_en && (addr == ADDR_CTRL);
	wire wr_flag  = wr_en && (addr == ADDR_FLAG);
	wire wr_div   = wr_en && (addr == ADDR_CLKDIV);
	wire wr_tx0   = wr_en && (addr == ADDR_TX0) && !pend_q;
	wire wr_tx1   = wr_en && (addr == ADDR_TX1) && !pend_q;
	wire wr_tx2   = wr_en && (addr == ADDR_TX2) && !pend_q;
	wire wr_gdir  = wr_en && (addr == ADDR_GDIR);
	wire wr_gout  = wr_en && (addr == ADDR_GOUT);
	wire rd_rx    = rd_en && (addr == ADDR_RXDATA);

	// events coming back from the link domains
	wire ack_ev   = tog_s[0] ^ tog_prev_q[0];
	wire end_ev   = tog_s[1] ^ tog_prev_q[1];
	wire rx_ev    = tog_s[2] ^ tog_prev_q[2];

	wire [DW-1:0] rd_mux =
		(addr == ADDR_CTRL)   ? {{(DW-CTRL_W){1'b0}}, ctrl_q} :
		(addr == ADDR_FLAG)   ? {{(DW-2){1'b0}}, flag_q} :
		(addr == ADDR_CLKDIV) ? {{(DW-DIV_W){1'b0}}, div_q} :
		(addr == ADDR_TX0)    ? tx0_q :
		(addr == ADDR_TX1)    ? tx1_q :
		(addr == ADDR_TX2)    ? tx2_q :
		(addr == ADDR_STATUS) ? {{(DW-2){1'b0}}, rx_full_q, pend_q} :
		(addr == ADDR_RXDATA) ? rx_data_q :
		(addr == ADDR_GDIR)   ? {{(DW-NPIN){1'b0}}, gdir_q} :
		(addr == ADDR_GOUT)   ? {{(DW-NPIN){1'b0}}, gout_q} :
		(addr == ADDR_GIN)    ? {{(DW-NPIN){1'b0}}, pin_s} :
		WORD_RST;

	sspi_sync2 #(.W(NPIN)) u_pin_sync (
		.clk (clk),
		.d   ({serial_ctrl_pin_c_i, serial_ctrl_pin_b_i, serial_ctrl_pin_a_i,
		       serial_bit_clock_pin_i, serial_rx_data_pin_i, serial_tx_data_pin_i}),
		.q   (pin_s)
	);

	sspi_sync2 #(.W(TOG_W)) u_tog_sync (
		.clk (clk),
		.d   ({rx_tog_q, end_tog_q, ack_tog_q}),
		.q   (tog_s)
	);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ctrl_q <= CTRL_RST;
			flag_q <= FLAG_RST;
			div_q  <= CLKDIV_RST;
			gdir_q <= GPIO_RST;
			gout_q <= GPIO_RST;
		end
		else if (ce)
		begin
			if (wr_ctrl) ctrl_q <= wdata[CTRL_W-1:0];
			if (wr_flag) flag_q <= wdata[1:0];
			if (wr_div)  div_q  <= wdata[DIV_W-1:0];
			if (wr_gdir) gdir_q <= wdata[NPIN-1:0];
			if (wr_gout) gout_q <= wdata[NPIN-1:0];
		end
	end

	// words are frozen while a transfer is pending, so the link reads them safely
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			tx0_q     <= WORD_RST;
			tx1_q     <= WORD_RST;
			tx2_q     <= WORD_RST;
			req_tog_q <= 1'b0;
			pend_q    <= 1'b0;
		end
		else if (ce)
		begin
			if (wr_tx0) tx0_q <= wdata;
			if (wr_tx1) tx1_q <= wdata;
			if (wr_tx2) tx2_q <= wdata;
			if (wr_tx0) req_tog_q <= ~req_tog_q;
			pend_q <= wr_tx0 | (pend_q & ~ack_ev);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			tog_prev_q <= {TOG_W{1'b0}};
			rx_data_q  <= WORD_RST;
			rx_full_q  <= 1'b0;
			rdata_q    <= WORD_RST;
		end
		else if (ce)
		begin
			tog_prev_q <= tog_s;
			if (rx_ev) rx_data_q <= rx_word_q;
			rx_full_q <= rx_ev | (rx_full_q & ~rd_rx); // new word beats the read clear
			rdata_q   <= rd_en ? rd_mux : WORD_RST;
		end
	end

	// bit clock divider; gated form parks low between frames
	wire clk_run    = port_en && ctrl_q[CTRL_CLK_OUT] && (!gated || run_q);
	wire clk_active = clk_run || bclk_q;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			run_q  <= 1'b0;
			bclk_q <= 1'b0;
			dcnt_q <= {DIV_W{1'b0}};
		end
		else if (ce)
		begin
			run_q <= wr_tx0 | (run_q & ~(end_ev & ~pend_q));
			if (!clk_active)
				dcnt_q <= {DIV_W{1'b0}};
			else if (dcnt_q == div_q)
			begin
				dcnt_q <= {DIV_W{1'b0}};
				bclk_q <= ~bclk_q;
			end
			else
				dcnt_q <= dcnt_q + 8'h01;
		end
	end

	// transmit section runs on the bit clock pin itself
	sspi_sync2 #(.W(TSYNC_W)) u_tx_sync (
		.clk (serial_bit_clock_pin_i),
		.d   ({req_tog_q, ctrl_q[CTRL_FS_OUT], ce, rst_n}),
		.q   (tsync)
	);

	wire t_rst_n = tsync[0];
	wire t_ce    = tsync[1];
	wire t_fsgen = tsync[2];
	wire t_pend  = tsync[3] ^ ack_tog_q;
	wire t_idle  = (tstate_q == SEQ_IDLE);
	wire t_last  = (tstate_q == SEQ_SHIFT) && (tcnt_q == CNT_LAST);
	wire t_shift = (tstate_q == SEQ_SHIFT) && !t_last;
	wire t_start = t_idle && t_pend && (t_fsgen || serial_ctrl_pin_c_i);

	always_ff @(posedge serial_bit_clock_pin_i)
	begin
		if (!t_rst_n)
		begin
			tstate_q  <= SEQ_IDLE;
			tcnt_q    <= {CNT_W{1'b0}};
			ack_tog_q <= 1'b0;
			end_tog_q <= 1'b0;
			fs_q      <= 1'b0;
		end
		else if (t_ce)
		begin
			fs_q <= t_start & t_fsgen;
			case (tstate_q)
				SEQ_IDLE:
					if (t_start)
					begin
						tstate_q  <= SEQ_SHIFT;
						tcnt_q    <= {CNT_W{1'b0}};
						ack_tog_q <= ~ack_tog_q;
					end
				SEQ_SHIFT:
					if (t_last)
					begin
						tstate_q  <= SEQ_IDLE;
						end_tog_q <= ~end_tog_q;
					end
					else
						tcnt_q <= tcnt_q + 4'h1;
				default:
					tstate_q <= SEQ_IDLE;
			endcase
		end
	end

	sspi_lane u_tx0 (
		.clk(serial_bit_clock_pin_i), .rst_n(t_rst_n), .ce(t_ce), .load(t_start),
		.word_in(tx0_q), .shift(t_shift), .ser_in(1'b0), .ser_out(tx0_ser), .word()
	);
	sspi_lane u_tx1 (
		.clk(serial_bit_clock_pin_i), .rst_n(t_rst_n), .ce(t_ce), .load(t_start),
		.word_in(tx1_q), .shift(t_shift), .ser_in(1'b0), .ser_out(tx1_ser), .word()
	);
	sspi_lane u_tx2 (
		.clk(serial_bit_clock_pin_i), .rst_n(t_rst_n), .ce(t_ce), .load(t_start),
		.word_in(tx2_q), .shift(t_shift), .ser_in(1'b0), .ser_out(tx2_ser), .word()
	);

	// mode is static while in use; changing it mid-frame glitches the receive clock
	wire rx_clk = async_md ? serial_ctrl_pin_a_i : serial_bit_clock_pin_i;

	sspi_sync2 #(.W(RSYNC_W)) u_rx_sync (
		.clk (rx_clk),
		.d   ({ctrl_q[CTRL_RX_EN], ctrl_q[CTRL_B_OUT], ctrl_q[CTRL_FS_OUT],
		       async_md, ce, rst_n}),
		.q   (rsync)
	);

	wire r_rst_n = rsync[0];
	wire r_ce    = rsync[1];
	wire r_async = rsync[2];
	wire r_fsgen = rsync[3];
	wire r_bgen  = rsync[4];
	wire r_en    = rsync[5];
	// in sync mode fs_q shares this clock, so it is read directly
	wire r_fs    = r_async ? (r_bgen ? rfs_q : serial_ctrl_pin_b_i)
	                       : (r_fsgen ? fs_q : serial_ctrl_pin_c_i);
	wire r_idle  = (rstate_q == SEQ_IDLE);
	wire r_start = r_idle && r_en && r_fs;
	wire r_last  = (rstate_q == SEQ_SHIFT) && (rcnt_q == CNT_LAST);

	always_ff @(posedge rx_clk)
	begin
		if (!r_rst_n)
		begin
			rstate_q  <= SEQ_IDLE;
			rcnt_q    <= {CNT_W{1'b0}};
			rx_tog_q  <= 1'b0;
			rfs_q     <= 1'b0;
			rx_word_q <= WORD_RST;
		end
		else if (r_ce)
		begin
			rfs_q <= r_async && r_bgen && r_en && r_idle && !rfs_q;
			case (rstate_q)
				SEQ_IDLE:
					if (r_start)
					begin
						rstate_q <= SEQ_SHIFT;
						rcnt_q   <= CNT_FIRST;
					end
				SEQ_SHIFT:
					if (r_last)
					begin
						rstate_q  <= SEQ_IDLE;
						rx_word_q <= {rlane_word[DW-2:0], serial_rx_data_pin_i};
						rx_tog_q  <= ~rx_tog_q;
					end
					else
						rcnt_q <= rcnt_q + 4'h1;
				default:
					rstate_q <= SEQ_IDLE;
			endcase
		end
	end

	sspi_lane u_rx (
		.clk(rx_clk), .rst_n(r_rst_n), .ce(r_ce), .load(1'b0), .word_in(WORD_RST),
		.shift(r_start || (rstate_q == SEQ_SHIFT)), .ser_in(serial_rx_data_pin_i),
		.ser_out(), .word(rlane_word)
	);

	// pin roles; gpio takes every pin while the port is off
	assign serial_tx_data_pin_o   = port_en ? tx0_ser : gout_q[PIN_TXD];
	assign serial_tx_data_pin_oe  = port_en ? 1'b1 : gdir_q[PIN_TXD];
	assign serial_rx_data_pin_o   = gout_q[PIN_RXD];
	assign serial_rx_data_pin_oe  = port_en ? 1'b0 : gdir_q[PIN_RXD];
	assign serial_bit_clock_pin_o = port_en ? bclk_q : gout_q[PIN_BCLK];
	assign serial_bit_clock_pin_oe = port_en ? ctrl_q[CTRL_CLK_OUT] : gdir_q[PIN_BCLK];

	wire a_tx = !async_md && ctrl_q[CTRL_A_TX];
	wire b_tx = !async_md && ctrl_q[CTRL_B_TX];
	wire a_sv = async_md ? bclk_q : (a_tx ? tx1_ser : flag_q[0]);
	wire b_sv = async_md ? rfs_q : (b_tx ? tx2_ser : flag_q[1]);

	assign serial_ctrl_pin_a_o  = port_en ? a_sv : gout_q[PIN_A];
	assign serial_ctrl_pin_a_oe = port_en ? (a_tx || ctrl_q[CTRL_A_OUT]) : gdir_q[PIN_A];
	assign serial_ctrl_pin_b_o  = port_en ? b_sv : gout_q[PIN_B];
	assign serial_ctrl_pin_b_oe = port_en ? (b_tx || ctrl_q[CTRL_B_OUT]) : gdir_q[PIN_B];
	assign serial_ctrl_pin_c_o  = port_en ? fs_q : gout_q[PIN_C];
	assign serial_ctrl_pin_c_oe = port_en ? ctrl_q[CTRL_FS_OUT] : gdir_q[PIN_C];

	assign rdata = rdata_q;
endmodule // sspi_top

// File: sspi_top_asserts.sv
`timescale 1ns/10ps
module sspi_checker (
	input wire logic                    clk,
	input wire logic                    rst_n,
	input wire logic                    ce,
	input wire logic [sspi_pkg::AW-1:0] addr,
	input wire logic [sspi_pkg::DW-1:0] wdata,
	input wire logic                    wr_en,
	input wire logic                    serial_tx_data_pin_oe,
	input wire logic                    serial_rx_data_pin_oe,
	input wire logic                    serial_bit_clock_pin_i,
	input wire logic                    serial_bit_clock_pin_oe,
	input wire logic                    serial_ctrl_pin_a_o,
	input wire logic                    serial_ctrl_pin_a_oe,
	input wire logic                    serial_ctrl_pin_b_o,
	input wire logic                    serial_ctrl_pin_b_oe,
	input wire logic                    serial_ctrl_pin_c_o,
	input wire logic                    serial_ctrl_pin_c_oe
);
	import sspi_pkg::*;
	// shadow copies of the ctrl, flag and gdir registers the pin muxes depend on
	logic [CTRL_W-1:0] ctrl_q;
	logic [1:0]        flag_q;
	logic [NPIN-1:0]   gdir_q;
	wire               take = wr_en && ce;
	wire               en = ctrl_q[CTRL_EN];
	wire               sync_on = en && !ctrl_q[CTRL_ASYNC];
	wire               async_on = en && ctrl_q[CTRL_ASYNC];
	wire  [NPIN-1:0]   oe_v = {serial_ctrl_pin_c_oe, serial_ctrl_pin_b_oe, serial_ctrl_pin_a_oe,
		serial_bit_clock_pin_oe, serial_rx_data_pin_oe, serial_tx_data_pin_oe};
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ctrl_q <= CTRL_RST;
			flag_q <= FLAG_RST;
			gdir_q <= GPIO_RST;
		end
		else if (take)
		begin
			if (addr == ADDR_CTRL) ctrl_q <= wdata[CTRL_W-1:0];
			if (addr == ADDR_FLAG) flag_q <= wdata[1:0];
			if (addr == ADDR_GDIR) gdir_q <= wdata[NPIN-1:0];
		end
	end
	a_gpio_dir: assert property (@(posedge clk) disable iff (!rst_n)
		!en |-> oe_v == gdir_q) else $error("pin enables differ from gpio direction");
	a_rx_pin_free: assert property (@(posedge clk) disable iff (!rst_n)
		en |-> !serial_rx_data_pin_oe) else $error("receive pin driven while port on");
	a_sync_a_tx: assert property (@(posedge clk) disable iff (!rst_n)
		sync_on && ctrl_q[CTRL_A_TX] |-> serial_ctrl_pin_a_oe) else $error("pin a not driving tx1");
	a_flag_a_out: assert property (@(posedge clk) disable iff (!rst_n)
		sync_on && !ctrl_q[CTRL_A_TX] && ctrl_q[CTRL_A_OUT]
		|-> serial_ctrl_pin_a_oe && serial_ctrl_pin_a_o == flag_q[0]) else $error("flag 0 wrong");
	a_flag_b_out: assert property (@(posedge clk) disable iff (!rst_n)
		sync_on && !ctrl_q[CTRL_B_TX] && ctrl_q[CTRL_B_OUT]
		|-> serial_ctrl_pin_b_oe && serial_ctrl_pin_b_o == flag_q[1]) else $error("flag 1 wrong");
	a_async_pins: assert property (@(posedge clk) disable iff (!rst_n)
		async_on |-> serial_ctrl_pin_a_oe == ctrl_q[CTRL_A_OUT]
		&& serial_ctrl_pin_b_oe == ctrl_q[CTRL_B_OUT]) else $error("async pin roles wrong");
	a_fs_dir: assert property (@(posedge clk) disable iff (!rst_n)
		en |-> serial_ctrl_pin_c_oe == ctrl_q[CTRL_FS_OUT]) else $error("pin c direction wrong");
	a_bclk_dir: assert property (@(posedge clk) disable iff (!rst_n)
		en |-> serial_bit_clock_pin_oe == ctrl_q[CTRL_CLK_OUT]) else $error("bit clock dir wrong");
	a_fs_one_bit: assert property (@(posedge serial_bit_clock_pin_i) disable iff (!rst_n)
		en && serial_ctrl_pin_c_oe && $rose(serial_ctrl_pin_c_o) |=> !serial_ctrl_pin_c_o)
		else $error("frame sync longer than one bit");
	c_frame: cover property (@(posedge serial_bit_clock_pin_i) en && $rose(serial_ctrl_pin_c_o));
	c_async: cover property (@(posedge clk) async_on && serial_ctrl_pin_a_oe);
	c_gpio: cover property (@(posedge clk) !en && oe_v != 6'h00);
endmodule // sspi_checker

bind sspi_top sspi_checker u_checker (.*);

// File: sspi_top_bench.sv
`timescale 1ns/10ps
module sspi_top_bench;
	import sspi_pkg::*;
	logic          clk, rst_n, ce, wr_en, rd_en, echo_en, codec_clk, codec_rxd, codec_rxd_oe;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata, rdata, rv, w0, w1, w2;
	logic [7:0]    frames;
	logic          serial_tx_data_pin_o, serial_tx_data_pin_oe, serial_rx_data_pin_o;
	logic          serial_rx_data_pin_oe, serial_bit_clock_pin_o, serial_bit_clock_pin_oe;
	logic          serial_ctrl_pin_a_o, serial_ctrl_pin_a_oe, serial_ctrl_pin_b_o;
	logic          serial_ctrl_pin_b_oe, serial_ctrl_pin_c_o, serial_ctrl_pin_c_oe;
	wire           serial_tx_data_pin_i, serial_rx_data_pin_i, serial_bit_clock_pin_i;
	wire           serial_ctrl_pin_a_i, serial_ctrl_pin_b_i, serial_ctrl_pin_c_i;
	int            bad_count, num_checks, cycles;
	wire  [5:0]    oe_v = {serial_ctrl_pin_c_oe, serial_ctrl_pin_b_oe, serial_ctrl_pin_a_oe,
		serial_bit_clock_pin_oe, serial_rx_data_pin_oe, serial_tx_data_pin_oe};
	wire  [5:0]    o_v = {serial_ctrl_pin_c_o, serial_ctrl_pin_b_o, serial_ctrl_pin_a_o,
		serial_bit_clock_pin_o, serial_rx_data_pin_o, serial_tx_data_pin_o};
	// board pull-downs on every released pin except the bit clock and the rx data pin, which the codec drives
	assign serial_tx_data_pin_i = serial_tx_data_pin_oe & serial_tx_data_pin_o;
	assign serial_rx_data_pin_i = serial_rx_data_pin_oe ? serial_rx_data_pin_o
		: codec_rxd_oe & codec_rxd;
	assign serial_bit_clock_pin_i = serial_bit_clock_pin_oe ? serial_bit_clock_pin_o : codec_clk;
	assign serial_ctrl_pin_a_i = serial_ctrl_pin_a_oe & serial_ctrl_pin_a_o;
	assign serial_ctrl_pin_b_i = serial_ctrl_pin_b_oe & serial_ctrl_pin_b_o;
	assign serial_ctrl_pin_c_i = serial_ctrl_pin_c_oe & serial_ctrl_pin_c_o;
	sspi_top u_dut (.*);
	sspi_codec u_codec (.bclk(codec_clk), .echo_en(echo_en), .bclk_w(serial_bit_clock_pin_i),
		.txd(serial_tx_data_pin_i), .pin_a(serial_ctrl_pin_a_i), .pin_b(serial_ctrl_pin_b_i),
		.pin_c(serial_ctrl_pin_c_i), .rxd_o(codec_rxd), .rxd_oe(codec_rxd_oe),
		.w0(w0), .w1(w1), .w2(w2), .frames(frames));
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic close_out();
		if (bad_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			bad_count++;
			close_out();
		end
	end
	task automatic chk(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [AW-1:0] a);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		rv = rdata;
	endtask
	task automatic rises(output int n);
		logic p;
		n = 0;
		p = serial_bit_clock_pin_o;
		repeat (40)
		begin
			@(posedge clk);
			#1;
			if (serial_bit_clock_pin_o === 1'b1 && p === 1'b0) n++;
			p = serial_bit_clock_pin_o;
		end
	endtask
	task automatic wait_frame(input logic [7:0] f);
		for (int i = 0; i < 2000 && frames === f; i++) @(posedge clk);
		chk({8'h00, frames}, {8'h00, f + 8'h01});
	endtask
	task automatic t_gpio();
		wr(ADDR_GDIR, 16'h000f);
		wr(ADDR_GOUT, 16'h000b);
		@(posedge clk);
		chk({10'h000, oe_v}, 16'h000f);
		chk({10'h000, o_v & oe_v}, 16'h000b);
		repeat (4) @(posedge clk);
		rd(ADDR_GIN);
		chk(rv, 16'h000b);
		wr(ADDR_GDIR, 16'h0000);
	endtask
	task automatic t_ctrl();
		wr(ADDR_FLAG, 16'h0001);
		wr(ADDR_CTRL, 16'h0061);
		@(posedge clk);
		chk({12'h000, serial_ctrl_pin_a_oe, serial_ctrl_pin_a_o, serial_ctrl_pin_b_oe,
			serial_ctrl_pin_b_o}, 16'h000e);
		// clock enable low: this write must not land
		ce <= 1'b0;
		wr(ADDR_FLAG, 16'h0002);
		ce <= 1'b1;
		rd(ADDR_FLAG);
		chk(rv, 16'h0001);
		wr(ADDR_CTRL, 16'h0000);
		wr(ADDR_CTRL, 16'h0003);
		@(posedge clk);
		chk({14'h0000, serial_ctrl_pin_a_oe, serial_ctrl_pin_b_oe}, 16'h0000);
		wr(ADDR_CTRL, 16'h0000);
		wr(ADDR_CTRL, 16'h0063);
		@(posedge clk);
		chk({14'h0000, serial_ctrl_pin_a_oe, serial_ctrl_pin_b_oe}, 16'h0003);
		wr(ADDR_CTRL, 16'h0000);
	endtask
	task automatic t_frame(input logic [DW-1:0] d0, input logic [DW-1:0] d1,
		input logic [DW-1:0] d2);
		logic [7:0] f;
		f = frames;
		wr(ADDR_TX1, d1);
		wr(ADDR_TX2, d2);
		wr(ADDR_TX0, d0);
		// second write is dropped while the first is still pending
		wr(ADDR_TX0, ~d0);
		wait_frame(f);
		chk(w0, d0);
		chk(w1, d1);
		chk(w2, d2);
		rd(ADDR_TX0);
		chk(rv, d0);
		for (int i = 0; i < 100; i++)
		begin
			rd(ADDR_STATUS);
			if (rv[1] === 1'b1) break;
		end
		rd(ADDR_RXDATA);
		chk(rv, d0);
		rd(ADDR_STATUS);
		chk(rv, 16'h0000);
	endtask
	task automatic t_clock();
		int n;
		wr(ADDR_CTRL, 16'h001d);
		rises(n);
		chk(16'(n), 16'h0000);
		wr(ADDR_TX0, 16'hc3a5);
		rises(n);
		chk(16'(n > 3), 16'h0001);
		wait_frame(frames);
		chk(w0, 16'hc3a5);
		repeat (20) @(posedge clk);
		rises(n);
		chk(16'(n), 16'h0000);
		wr(ADDR_CTRL, 16'h0000);
		wr(ADDR_CTRL, 16'h0015);
		rises(n);
		chk(16'(n), 16'(40 / (2 * (int'(CLKDIV_RST) + 1))));
		wr(ADDR_CTRL, 16'h0000);
	endtask
	initial
	begin
		rst_n = 1'b0;
		ce = 1'b1;
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 4'h0;
		wdata = 16'h0000;
		echo_en = 1'b0;
		repeat (12) @(posedge clk);
		chk({10'h000, oe_v}, 16'h0000);
		rst_n <= 1'b1;
		t_gpio();
		t_ctrl();
		wr(ADDR_CTRL, 16'h0391);
		echo_en <= 1'b1;
		t_frame(16'ha5c3, 16'h1234, 16'h8001);
		t_frame(16'h0f0f, 16'hfedc, 16'h7ffe);
		wr(ADDR_CTRL, 16'h0000);
		echo_en <= 1'b0;
		t_clock();
		close_out();
	end
endmodule // sspi_top_bench
